// ==== core/redriver_defines.svh ====
`ifndef REDRIVER_DEFINES_SVH
`define REDRIVER_DEFINES_SVH
// Behaviour
// - Four linear swings by register; strap uses highest
// - Limited swing host-facing only, off until enabled
// - Preshoot level used when limited and enabled
// - De-emphasis level used when limited and enabled
// - No transmit equalization control in strap mode
// - Orientation alone picks config lane
// - Non-config lane off outside U0 (Disconnect, U1, U2/U3) when two_lane_i high; else always on
// - Config lane decides entry/exit; exit re-enables other
// - Sleep low in U3: termination kept, LFPS ignored
// - Sleep low in Disconnect: termination, detection off
// - Sleep high resumes far-end termination detection
// - One sleep input acts on both ports
// - Mode pin picks register or strap mode
// - Host receiver EQ decoded from straps and scheme
// - Connector receiver EQ decoded when adaptive EQ off
// - Disconnect until both terminations seen, then U0
// - U0 redrives until both idle, then U1
// - U1 keeps termination and transmit common mode
// - U2/U3 periodic detection; missing termination disconnects
// - Valid LFPS in U2/U3 goes to U0
// - U2/U3 keeps termination, drops common mode
// - Register bit blocks U1 and U2; strap cannot

// Four-level pin codes
`define LVL_0 2'h0
`define LVL_R 2'h1
`define LVL_F 2'h2
`define LVL_1 2'h3

`define MODE_I2C   `LVL_F
`define MODE_STRAP `LVL_1

`define SWING_MAX 2'h3
`define TXEQ_OFF  2'h0

`define CLK_PERIOD_PS    4000
`define RXDET_PERIOD_NS  12000
`define RXDET_PERIOD_CYC ((`RXDET_PERIOD_NS * 1000) / `CLK_PERIOD_PS)
`define U1_IDLE_NS       2000
`define U1_IDLE_CYC      ((`U1_IDLE_NS * 1000) / `CLK_PERIOD_PS)
`endif

// ==== core/redriver_pkg.sv ====
package redriver_pkg;
  typedef enum logic [1:0] {DISCONNECT, U0, U1, U2U3} link_state_t;

  typedef struct packed {
    logic far_term_ufp;
    logic far_term_dfp;
    logic idle_ufp;
    logic idle_dfp;
    logic lfps_valid;
  } lane_status_t;

  typedef struct packed {
    logic       preshoot_enable;
    logic [1:0] preshoot_level;
    logic       deemph_enable;
    logic [1:0] deemph_level;
  } tx_eq_t;

  typedef struct packed {
    logic       per_pin;
    logic [3:0] setting;
  } rx_eq_t;
endpackage

// ==== core/redriver_lane_power_control.sv ====
`timescale 1ns/1ps
`include "redriver_defines.svh"
module redriver_lane_power_control
  import redriver_pkg::*;
#(
  parameter int RXDET_CYC   = `RXDET_PERIOD_CYC,
  parameter int U1_IDLE_CYC = `U1_IDLE_CYC
) (
  input  wire logic               core_clk_i,
  input  wire logic               reset_n_i,
  input  wire logic               clk_en_i,
  input  wire logic [1:0]         mode_strap_i,
  input  wire logic [1:0]         eq_strap_scheme_i,
  input  wire logic [1:0]         host_rx_eq_strap_0_i,
  input  wire logic [1:0]         host_rx_eq_strap_1_i,
  input  wire logic [1:0]         conn_rx_eq_strap_0_i,
  input  wire logic [1:0]         conn_rx_eq_strap_1_i,
  input  wire logic               adaptive_eq_on_i,
  input  wire logic [1:0][3:0]    host_rx_eq_reg_i,
  input  wire logic [1:0][3:0]    conn_rx_eq_reg_i,
  input  wire logic [1:0]         linear_swing_level_i,
  input  wire logic               limit_mode_enable_i,
  input  wire logic [1:0]         limited_swing_level_i,
  input  wire tx_eq_t [1:0]       lane_tx_eq_i,
  input  wire logic               orientation_select_i,
  input  wire logic               two_lane_i,
  input  wire logic               low_power_state_disable_i,
  input  wire logic               sleep_detect_inhibit_n_i,
  input  wire lane_status_t [1:0] lane_status_i,
  output logic                    reg_mode_o,
  output logic                    strap_mode_o,
  output logic                    mode_reserved_o,
  output link_state_t             link_state_o,
  output logic                    config_lane_o,
  output logic [1:0]              lane_enable_o,
  output logic [1:0]              rx_term_o,
  output logic                    rx_detect_active_o,
  output logic                    rx_detect_pulse_o,
  output logic                    tx_cm_hold_o,
  output logic                    redrive_o,
  output logic [1:0]              linear_swing_o,
  output logic                    host_tx_limited_o,
  output logic [1:0]              host_tx_swing_o,
  output tx_eq_t [1:0]            host_tx_eq_o,
  output rx_eq_t [1:0]            host_rx_eq_o,
  output rx_eq_t [1:0]            conn_rx_eq_o
);

  typedef struct packed {
    link_state_t   link;
    logic [15:0]   timer;
    logic          straps_taken;
    logic [1:0]    mode;
    logic          config_lane;
    logic [1:0]    lane_en;
    logic [1:0]    rx_term;
    logic          rx_detect_active;
    logic          rx_detect_pulse;
    logic          tx_cm_hold;
    logic          redrive;
    logic [1:0]    linear_swing;
    logic          host_tx_limited;
    logic [1:0]    host_tx_swing;
    tx_eq_t [1:0]  tx_eq;
    rx_eq_t [1:0]  host_rx_eq;
    rx_eq_t [1:0]  conn_rx_eq;
  } core_state_t;

  core_state_t state;
  core_state_t next_state;

  logic         reg_mode;
  logic         strap_mode;
  logic         cfg;
  lane_status_t cs;
  logic         lp_allowed;
  logic         sleep_n;

  assign reg_mode   = state.straps_taken && (state.mode == `MODE_I2C);
  assign strap_mode = state.straps_taken && (state.mode == `MODE_STRAP);
  assign cfg        = orientation_select_i;
  assign cs         = lane_status_i[cfg];
  assign lp_allowed = !(reg_mode && low_power_state_disable_i);
  assign sleep_n    = sleep_detect_inhibit_n_i;

  always_comb begin
    next_state = state;
    next_state.rx_detect_pulse = 1'b0;

    // Straps are only trusted once; later pin motion is ignored
    if (!state.straps_taken) begin
      next_state.straps_taken = 1'b1;
      next_state.mode         = mode_strap_i;
      next_state.host_rx_eq[0].per_pin = eq_strap_scheme_i inside {`LVL_1, `LVL_R};
      next_state.host_rx_eq[1].per_pin = eq_strap_scheme_i inside {`LVL_1, `LVL_R};
      next_state.host_rx_eq[0].setting = next_state.host_rx_eq[0].per_pin ?
        {2'h0, host_rx_eq_strap_0_i} : {host_rx_eq_strap_1_i, host_rx_eq_strap_0_i};
      next_state.host_rx_eq[1].setting = next_state.host_rx_eq[1].per_pin ?
        {2'h0, host_rx_eq_strap_1_i} : {host_rx_eq_strap_1_i, host_rx_eq_strap_0_i};
      next_state.conn_rx_eq[0].per_pin = !adaptive_eq_on_i &&
        (eq_strap_scheme_i inside {`LVL_0, `LVL_R});
      next_state.conn_rx_eq[1].per_pin = next_state.conn_rx_eq[0].per_pin;
      next_state.conn_rx_eq[0].setting = next_state.conn_rx_eq[0].per_pin ?
        {2'h0, conn_rx_eq_strap_0_i} : {conn_rx_eq_strap_1_i, conn_rx_eq_strap_0_i};
      next_state.conn_rx_eq[1].setting = next_state.conn_rx_eq[1].per_pin ?
        {2'h0, conn_rx_eq_strap_1_i} : {conn_rx_eq_strap_1_i, conn_rx_eq_strap_0_i};
    end else if (reg_mode) begin
      for (int i = 0; i < 2; i++) begin
        next_state.host_rx_eq[i] = '{per_pin: 1'b0, setting: host_rx_eq_reg_i[i]};
        next_state.conn_rx_eq[i] = '{per_pin: 1'b0, setting: conn_rx_eq_reg_i[i]};
      end
    end

    next_state.linear_swing    = strap_mode ? `SWING_MAX : linear_swing_level_i;
    next_state.host_tx_limited = reg_mode && limit_mode_enable_i;
    next_state.host_tx_swing   = next_state.host_tx_limited ?
                                 limited_swing_level_i : next_state.linear_swing;
    for (int i = 0; i < 2; i++) begin
      // Strap mode never sets limited, so transmit EQ stays off there
      next_state.tx_eq[i].preshoot_enable =
        next_state.host_tx_limited && lane_tx_eq_i[i].preshoot_enable;
      next_state.tx_eq[i].preshoot_level = next_state.tx_eq[i].preshoot_enable ?
        lane_tx_eq_i[i].preshoot_level : `TXEQ_OFF;
      next_state.tx_eq[i].deemph_enable =
        next_state.host_tx_limited && lane_tx_eq_i[i].deemph_enable;
      next_state.tx_eq[i].deemph_level = next_state.tx_eq[i].deemph_enable ?
        lane_tx_eq_i[i].deemph_level : `TXEQ_OFF;
    end

    next_state.config_lane = cfg;
    next_state.timer       = state.timer + 16'h1;

    unique case (state.link)
      DISCONNECT: begin
        next_state.timer = 16'h0;
        if (sleep_n && cs.far_term_ufp && cs.far_term_dfp) begin
          next_state.link = U0;
        end
      end
      U0: begin
        next_state.timer = 16'h0;
        if (lp_allowed && cs.idle_ufp && cs.idle_dfp) begin
          next_state.link = U1;
        end
      end
      U1: begin
        if (!cs.idle_ufp || !cs.idle_dfp) begin
          next_state.link  = U0;
          next_state.timer = 16'h0;
        end else if (state.timer >= 16'(U1_IDLE_CYC - 1)) begin
          next_state.link  = U2U3;
          next_state.timer = 16'h0;
        end
      end
      U2U3: begin
        // Asleep: no detection, no wake, hold here
        if (!sleep_n) begin
          next_state.timer = 16'h0;
        end else if (cs.lfps_valid) begin
          next_state.link  = U0;
          next_state.timer = 16'h0;
        end else if (state.timer >= 16'(RXDET_CYC - 1)) begin
          next_state.timer           = 16'h0;
          next_state.rx_detect_pulse = 1'b1;
          if (!cs.far_term_ufp || !cs.far_term_dfp) begin
            next_state.link = DISCONNECT;
          end
        end
      end
    endcase

    // Outputs follow the state being entered so they stay in step
    next_state.lane_en[cfg]  = 1'b1;
    next_state.lane_en[!cfg] = !two_lane_i || (next_state.link == U0);
    for (int i = 0; i < 2; i++) begin
      next_state.rx_term[i] = next_state.lane_en[i] &&
        ((next_state.link != DISCONNECT) || sleep_n);
    end
    next_state.rx_detect_active = sleep_n && ((next_state.link == DISCONNECT) ||
                                  (next_state.link == U2U3));
    next_state.tx_cm_hold = (next_state.link == U0) || (next_state.link == U1);
    next_state.redrive    = (next_state.link == U0);
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= '0;
    end else if (clk_en_i) begin
      state <= next_state;
    end
  end

  assign reg_mode_o         = reg_mode;
  assign strap_mode_o       = strap_mode;
  assign mode_reserved_o    = state.straps_taken && !reg_mode && !strap_mode;
  assign link_state_o       = state.link;
  assign config_lane_o      = state.config_lane;
  assign lane_enable_o      = state.lane_en;
  assign rx_term_o          = state.rx_term;
  assign rx_detect_active_o = state.rx_detect_active;
  assign rx_detect_pulse_o  = state.rx_detect_pulse;
  assign tx_cm_hold_o       = state.tx_cm_hold;
  assign redrive_o          = state.redrive;
  assign linear_swing_o     = state.linear_swing;
  assign host_tx_limited_o  = state.host_tx_limited;
  assign host_tx_swing_o    = state.host_tx_swing;
  assign host_tx_eq_o       = state.tx_eq;
  assign host_rx_eq_o       = state.host_rx_eq;
  assign conn_rx_eq_o       = state.conn_rx_eq;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_strap_swing_max: assert property (
    clk_en_i && strap_mode |=> linear_swing_o == `SWING_MAX)
    else $error("strap mode swing not at maximum");
  a_reg_swing: assert property (
    clk_en_i && reg_mode |=> linear_swing_o == $past(linear_swing_level_i))
    else $error("register swing not applied");
  a_limit_needs_reg: assert property (
    clk_en_i && !(reg_mode && limit_mode_enable_i) |=> !host_tx_limited_o)
    else $error("limited swing without register enable");
  a_preshoot_gate: assert property (
    clk_en_i && !(limit_mode_enable_i && lane_tx_eq_i[0].preshoot_enable) |=>
    host_tx_eq_o[0].preshoot_level == `TXEQ_OFF)
    else $error("preshoot active without enables");
  a_deemph_follow: assert property (
    clk_en_i && reg_mode && limit_mode_enable_i && lane_tx_eq_i[1].deemph_enable |=>
    host_tx_eq_o[1].deemph_level == $past(lane_tx_eq_i[1].deemph_level))
    else $error("de-emphasis level not applied");
  a_strap_no_txeq: assert property (
    strap_mode_o |-> !host_tx_eq_o[0].preshoot_enable && !host_tx_eq_o[1].preshoot_enable &&
    !host_tx_eq_o[0].deemph_enable && !host_tx_eq_o[1].deemph_enable)
    else $error("transmit equalization in strap mode");
  a_cfg_lane: assert property (
    clk_en_i |=> config_lane_o == $past(orientation_select_i))
    else $error("config lane not from orientation");
  a_noncfg_off: assert property (
    clk_en_i && two_lane_i && next_state.link != U0 |=> !lane_enable_o[!config_lane_o])
    else $error("non-config lane on in low power");
  a_exit_lanes_on: assert property (
    clk_en_i && link_state_o == U2U3 && sleep_n && cs.lfps_valid |=> lane_enable_o == 2'h3)
    else $error("non-config lane not re-enabled on exit");
  a_u3_no_wake: assert property (
    clk_en_i && link_state_o == U2U3 && !sleep_n |=>
    link_state_o == U2U3 && rx_term_o[config_lane_o])
    else $error("left U2/U3 while sleep inhibit low");
  a_disc_sleep: assert property (
    clk_en_i && link_state_o == DISCONNECT && !sleep_n |=>
    rx_term_o == 2'h0 && !rx_detect_active_o)
    else $error("termination or detection active while asleep");
  a_detect_resume: assert property (
    clk_en_i && link_state_o == DISCONNECT && sleep_n &&
    !(cs.far_term_ufp && cs.far_term_dfp) |=> rx_detect_active_o)
    else $error("detection not resumed with sleep high");
  a_sleep_both: assert property (
    link_state_o == DISCONNECT && !rx_detect_active_o |-> rx_term_o == 2'h0)
    else $error("termination left on one port while asleep");
  a_mode_decode: assert property (
    clk_en_i && !state.straps_taken |=> reg_mode_o == ($past(mode_strap_i) == `MODE_I2C))
    else $error("mode not decoded from mode pin");
  a_host_eq_pin: assert property (
    clk_en_i && !state.straps_taken && eq_strap_scheme_i inside {`LVL_1, `LVL_R} |=>
    host_rx_eq_o[1].setting == {2'h0, $past(host_rx_eq_strap_1_i)})
    else $error("host receiver strap level not applied");
  a_disc_to_u0: assert property (
    clk_en_i && link_state_o == DISCONNECT && sleep_n && cs.far_term_ufp && cs.far_term_dfp |=>
    link_state_o == U0 && redrive_o)
    else $error("no U0 entry after termination");
  a_u0_to_u1: assert property (
    clk_en_i && link_state_o == U0 && lp_allowed && cs.idle_ufp && cs.idle_dfp |=>
    link_state_o == U1 && tx_cm_hold_o)
    else $error("no U1 entry after idle");
  a_u1_keep: assert property (
    link_state_o == U1 |-> tx_cm_hold_o && rx_term_o[config_lane_o])
    else $error("U1 lost termination or common mode");
  a_u2_detect_disc: assert property (
    clk_en_i && link_state_o == U2U3 && sleep_n && !cs.lfps_valid && !cs.far_term_ufp &&
    state.timer >= 16'(RXDET_CYC - 1) |=> link_state_o == DISCONNECT && rx_detect_pulse_o)
    else $error("missing termination not detected");
  a_pulse_in_u2: assert property (
    clk_en_i && link_state_o != U2U3 |=> !rx_detect_pulse_o)
    else $error("detection pulse outside U2/U3");
  a_lfps_wake: assert property (
    clk_en_i && link_state_o == U2U3 && sleep_n && cs.lfps_valid |=>
    link_state_o == U0 && tx_cm_hold_o)
    else $error("no wake on valid LFPS");
  a_u2_keep: assert property (
    link_state_o == U2U3 |-> !tx_cm_hold_o && rx_term_o[config_lane_o])
    else $error("U2/U3 termination or common mode wrong");
  a_lpd_block: assert property (
    reg_mode && low_power_state_disable_i && link_state_o == U0 |=> link_state_o == U0)
    else $error("low power entered while disabled");
  a_u1_exit: assert property (
    clk_en_i && link_state_o == U1 && !(cs.idle_ufp && cs.idle_dfp) |=> link_state_o == U0)
    else $error("U1 not left on activity");
  a_straps_held: assert property (
    reg_mode_o || strap_mode_o || mode_reserved_o |=>
    $stable({reg_mode_o, strap_mode_o, mode_reserved_o}))
    else $error("strap decode changed after capture");

  c_enter_u1: cover property (link_state_o == U0 ##1 link_state_o == U1);
  c_u2_wake: cover property (link_state_o == U2U3 ##1 link_state_o == U0);
  c_u2_disc: cover property (link_state_o == U2U3 ##1 link_state_o == DISCONNECT);
  c_limited: cover property (host_tx_limited_o && host_tx_eq_o[0].preshoot_enable);
  c_sleep_hold: cover property (link_state_o == U2U3 && !sleep_n ##1 link_state_o == U2U3);
endmodule

// ==== verification/link_partner_model.sv ====
`timescale 1ns/1ps
module link_partner_model
  import redriver_pkg::*;
(
  input  wire logic          core_clk_i,
  input  wire logic          reset_n_i,
  input  wire logic          cfg_i,
  input  wire logic          term_i,
  input  wire logic          idle_i,
  input  wire logic          lfps_i,
  output lane_status_t [1:0] lane_status_o
);
  lane_status_t st;
  assign st = {term_i, term_i, idle_i, idle_i, lfps_i};
  // Other lane shows the inverse, so using it instead of the config lane shows up
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lane_status_o <= '0;
    end else begin
      lane_status_o[cfg_i]  <= st;
      lane_status_o[!cfg_i] <= ~st;
    end
  end
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
module tb
  import redriver_pkg::*;
;
  logic core_clk_i = 0, reset_n_i = 0, clk_en_i = 1, adaptive_eq_on_i = 0;
  logic [1:0] mode_strap_i = 0, eq_strap_scheme_i = 0, linear_swing_level_i = 0;
  logic [1:0] host_rx_eq_strap_0_i = 0, host_rx_eq_strap_1_i = 0;
  logic [1:0] conn_rx_eq_strap_0_i = 0, conn_rx_eq_strap_1_i = 0, limited_swing_level_i = 0;
  logic [1:0][3:0] host_rx_eq_reg_i = 0, conn_rx_eq_reg_i = 0;
  logic limit_mode_enable_i = 0, orientation_select_i = 0, two_lane_i = 1;
  logic low_power_state_disable_i = 0, sleep_detect_inhibit_n_i = 1;
  logic term = 0, idle = 0, lfps = 0;
  tx_eq_t [1:0] lane_tx_eq_i = 0;
  lane_status_t [1:0] lane_status_i;
  logic reg_mode_o, strap_mode_o, mode_reserved_o, config_lane_o, rx_detect_active_o;
  logic rx_detect_pulse_o, tx_cm_hold_o, redrive_o, host_tx_limited_o;
  link_state_t link_state_o;
  logic [1:0] lane_enable_o, rx_term_o, linear_swing_o, host_tx_swing_o;
  tx_eq_t [1:0] host_tx_eq_o;
  rx_eq_t [1:0] host_rx_eq_o, conn_rx_eq_o;
  int bad_count = 0, comparisons = 0, cycles = 0, k;
  logic [31:0] seed = 32'h0001_1801;
  logic [31:0] r;
  logic [1:0] cfg_bit;
  logic conn_per;

  redriver_lane_power_control #(.RXDET_CYC(8), .U1_IDLE_CYC(4)) DUT (
    .core_clk_i, .reset_n_i, .clk_en_i, .mode_strap_i, .eq_strap_scheme_i,
    .host_rx_eq_strap_0_i, .host_rx_eq_strap_1_i, .conn_rx_eq_strap_0_i,
    .conn_rx_eq_strap_1_i, .adaptive_eq_on_i, .host_rx_eq_reg_i, .conn_rx_eq_reg_i,
    .linear_swing_level_i, .limit_mode_enable_i, .limited_swing_level_i, .lane_tx_eq_i,
    .orientation_select_i, .two_lane_i, .low_power_state_disable_i,
    .sleep_detect_inhibit_n_i, .lane_status_i, .reg_mode_o, .strap_mode_o,
    .mode_reserved_o, .link_state_o, .config_lane_o, .lane_enable_o, .rx_term_o,
    .rx_detect_active_o, .rx_detect_pulse_o, .tx_cm_hold_o, .redrive_o, .linear_swing_o,
    .host_tx_limited_o, .host_tx_swing_o, .host_tx_eq_o, .host_rx_eq_o, .conn_rx_eq_o);

  link_partner_model partner (.core_clk_i, .reset_n_i, .cfg_i(orientation_select_i),
    .term_i(term), .idle_i(idle), .lfps_i(lfps), .lane_status_o(lane_status_i));

  always #2 core_clk_i = ~core_clk_i;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic rx_eq_t exp_eq(logic per, logic [1:0] a, logic [1:0] b0, logic [1:0] b1);
    return per ? {1'b1, 2'b00, a} : {1'b0, b1, b0};
  endfunction

  function automatic tx_eq_t exp_tx(logic lim, tx_eq_t t);
    exp_tx = '0;
    if (lim && t.preshoot_enable) begin
      exp_tx.preshoot_enable = 1'b1;
      exp_tx.preshoot_level  = t.preshoot_level;
    end
    if (lim && t.deemph_enable) begin
      exp_tx.deemph_enable = 1'b1;
      exp_tx.deemph_level  = t.deemph_level;
    end
  endfunction

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic step(int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic wait_state(link_state_t s, int lim);
    for (int i = 0; i < lim && link_state_o !== s; i++) step(1);
    check("link_state", link_state_o, s);
  endtask

  task automatic do_reset(logic [1:0] m);
    reset_n_i = 0;
    mode_strap_i = m;
    term = 0;
    idle = 0;
    lfps = 0;
    sleep_detect_inhibit_n_i = 1;
    step(4);
    reset_n_i = 1;
    step(2);
  endtask

  task automatic summarize();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    low_power_state_disable_i = 1;
    for (k = 0; k < 4; k++) begin
      r = rnd();
      eq_strap_scheme_i = k[1:0];
      {conn_rx_eq_strap_1_i, conn_rx_eq_strap_0_i} = r[3:0];
      {host_rx_eq_strap_1_i, host_rx_eq_strap_0_i} = r[7:4];
      limit_mode_enable_i = 1;
      lane_tx_eq_i = r[19:8] | 12'h924;
      adaptive_eq_on_i = r[20];
      conn_per = !k[1] && !r[20];
      do_reset(2'h3);
      mode_strap_i = 2'h2;
      step(1);
      check("strap_mode", strap_mode_o, 1'b1);
      check("strap_held", reg_mode_o, 1'b0);
      check("linear_swing", linear_swing_o, 2'h3);
      check("limited", host_tx_limited_o, 1'b0);
      check("tx_eq", host_tx_eq_o, '0);
      check("host_eq0", host_rx_eq_o[0], exp_eq(k[0], r[5:4], r[5:4], r[7:6]));
      check("host_eq1", host_rx_eq_o[1], exp_eq(k[0], r[7:6], r[5:4], r[7:6]));
      check("conn_eq0", conn_rx_eq_o[0], exp_eq(conn_per, r[1:0], r[1:0], r[3:2]));
      check("conn_eq1", conn_rx_eq_o[1], exp_eq(conn_per, r[3:2], r[1:0], r[3:2]));
      term = 1;
      idle = 1;
      wait_state(U1, 8);
    end
    do_reset(2'h1);
    check("reserved", mode_reserved_o, 1'b1);
    low_power_state_disable_i = 0;
    do_reset(2'h2);
    check("reg_mode", reg_mode_o, 1'b1);
    for (k = 0; k < 12; k++) begin
      r = rnd();
      {linear_swing_level_i, limited_swing_level_i, limit_mode_enable_i} = r[4:0];
      lane_tx_eq_i = r[16:5];
      {host_rx_eq_reg_i, conn_rx_eq_reg_i} = r[31:16];
      step(2);
      check("linear_swing", linear_swing_o, r[4:3]);
      check("limited", host_tx_limited_o, r[0]);
      check("tx_swing", host_tx_swing_o, r[0] ? r[2:1] : r[4:3]);
      check("host_eq_reg0", host_rx_eq_o[0], {1'b0, r[27:24]});
      check("host_eq_reg1", host_rx_eq_o[1], {1'b0, r[31:28]});
      check("conn_eq_reg0", conn_rx_eq_o[0], {1'b0, r[19:16]});
      check("conn_eq_reg1", conn_rx_eq_o[1], {1'b0, r[23:20]});
      check("tx_eq0", host_tx_eq_o[0], exp_tx(r[0], r[10:5]));
      check("tx_eq1", host_tx_eq_o[1], exp_tx(r[0], r[16:11]));
    end
    for (k = 0; k < 2; k++) begin
      orientation_select_i = k[0];
      cfg_bit = k[0] ? 2'b10 : 2'b01;
      do_reset(2'h2);
      step(3);
      check("disc_hold", link_state_o, DISCONNECT);
      term = 1;
      wait_state(U0, 4);
      check("config_lane", config_lane_o, k[0]);
      check("lanes_u0", lane_enable_o, 2'b11);
      check("redrive", redrive_o, 1'b1);
      idle = 1;
      wait_state(U1, 4);
      check("lanes_u1", lane_enable_o, cfg_bit);
      check("cm_u1", tx_cm_hold_o, 1'b1);
      check("term_u1", rx_term_o, cfg_bit);
      wait_state(U2U3, 12);
      check("cm_u2", tx_cm_hold_o, 1'b0);
      check("term_u2", rx_term_o, cfg_bit);
      lfps = 1;
      wait_state(U0, 4);
      check("lanes_exit", lane_enable_o, 2'b11);
      lfps = 0;
      wait_state(U2U3, 16);
      sleep_detect_inhibit_n_i = 0;
      lfps = 1;
      term = 0;
      step(20);
      check("sleep_u3", link_state_o, U2U3);
      check("sleep_term", rx_term_o, cfg_bit);
      check("sleep_nodet", rx_detect_active_o, 1'b0);
      lfps = 0;
      // Partner must drop its LFPS first, or waking sees a real wake request
      step(1);
      sleep_detect_inhibit_n_i = 1;
      wait_state(DISCONNECT, 20);
      check("detect_pulse", rx_detect_pulse_o, 1'b1);
      check("detect_on", rx_detect_active_o, 1'b1);
      sleep_detect_inhibit_n_i = 0;
      term = 1;
      step(4);
      check("sleep_disc", link_state_o, DISCONNECT);
      check("term_off", rx_term_o, 2'b00);
      check("detect_off", rx_detect_active_o, 1'b0);
      check("pulse_end", rx_detect_pulse_o, 1'b0);
      sleep_detect_inhibit_n_i = 1;
      wait_state(U0, 4);
    end
    low_power_state_disable_i = 1;
    do_reset(2'h2);
    term = 1;
    idle = 1;
    step(12);
    check("lpd_block", link_state_o, U0);
    // Enable low: nothing may advance although U1 is now allowed
    low_power_state_disable_i = 0;
    clk_en_i = 0;
    step(4);
    check("frozen", link_state_o, U0);
    clk_en_i = 1;
    step(1);
    check("unfrozen", link_state_o, U1);
    idle = 0;
    wait_state(U0, 4);
    summarize();
  end
endmodule
